// ### input_remap_pkg.sv
/*
 * Constants, register map and carrier types for the peripheral input
 * remap selector. Assumes a 32-bit APB slave on pclk, 20 MHz.
 */
// Operation
// - Each peripheral input selector is a 7-bit writable source code
// - Code zero ties the peripheral input low
// - Code one routes comparator one output to the input
// - CAN and PWM sync selectors reach input-only pin 124 by code 124
// - UART and SPI selectors reach pin 124 by the all-ones code
// - Bit 15 of two-field registers ignores writes, reads zero
// - Bit 7 of two-field registers ignores writes, reads zero
// - CAN register: second CAN upper field, first CAN lower field
// - CAN register exists only on variants with CAN receivers
// - UART three register: clear-to-send upper, receive lower
// - UART four register: clear-to-send upper, receive lower
// - SPI three register: clock upper, data in lower
// - SPI slave-select uses bits 6-0, bits 15-7 read zero
// - PWM sync one uses bits 14-8, low byte reads zero
package input_remap_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] CAN_SEL_OFF   = 12'h000;
	localparam logic [11:0] UART_C_OFF    = 12'h004;
	localparam logic [11:0] UART_D_OFF    = 12'h008;
	localparam logic [11:0] SPI_CD_OFF    = 12'h00c;
	localparam logic [11:0] SPI_SS_OFF    = 12'h010;
	localparam logic [11:0] PWM_SYNC_OFF  = 12'h014;

	// ----------------------------------------------------------------
	// Field layout and codes
	// ----------------------------------------------------------------
	localparam int          SEL_W      = 7;
	localparam int          HI_LSB     = 8;
	localparam int          LO_LSB     = 0;
	localparam logic [6:0]  CODE_VSS   = 7'h00;
	localparam logic [6:0]  CODE_COMPARATOR_ONE_OUTPUT  = 7'h01;
	localparam logic [6:0]  CODE_IPIN  = 7'h7c;
	localparam logic [6:0]  CODE_ONES  = 7'h7f;
	localparam logic [6:0]  SEL_RESET  = 7'h00;
	localparam int          PIN_COUNT  = 128;

	// Selector set, one field per remapped peripheral input
	typedef struct packed {
		logic [6:0] can_b_rx_source;
		logic [6:0] can_a_rx_source;
		logic [6:0] uart_c_cts_source;
		logic [6:0] uart_c_rx_source;
		logic [6:0] uart_d_cts_source;
		logic [6:0] uart_d_rx_source;
		logic [6:0] spi_c_clock_source;
		logic [6:0] spi_c_data_in_source;
		logic [6:0] spi_c_select_source;
		logic [6:0] pwm_sync_one_source;
	} sel_t;

	// Routed peripheral inputs
	typedef struct packed {
		logic can_b_receive_input;
		logic can_a_receive_input;
		logic uart_c_clear_to_send;
		logic uart_c_receive_input;
		logic uart_d_clear_to_send;
		logic uart_d_receive_input;
		logic spi_c_clock_input;
		logic spi_c_data_input;
		logic spi_c_slave_select_input;
		logic pwm_sync_input;
	} periph_in_t;

endpackage

// ### peripheral_input_remap_select.sv
/*
 * Peripheral input remap selector: six APB registers of source codes
 * steer pins or comparator one onto ten peripheral inputs.
 * Assumes pins and comparator output are asynchronous to pclk and are
 * synchronised here; peripherals sit on pclk.
 */
`timescale 1ns/1ps

module peripheral_input_remap_select #(
	parameter bit HAS_CAN = 1'b1
) (
	input  wire logic        pclk,        // System clock
	input  wire logic        presetn,     // Async reset, low
	input  wire logic        clk_en,      // Freezes state when low
	input  wire logic        psel,        // APB select
	input  wire logic        penable,     // APB access phase
	input  wire logic        pwrite,      // APB write
	input  wire logic [11:0] paddr,       // APB byte address
	input  wire logic [31:0] pwdata,      // APB write data
	output logic      [31:0] prdata,      // APB read data
	output logic             pready,      // APB ready
	output logic             pslverr,     // APB error
	input  wire logic [127:0] remappable_pin, // Pin levels by number
	input  wire logic        comparator_one_output, // Comparator one
	output input_remap_pkg::periph_in_t periph_in // Routed inputs
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		input_remap_pkg::sel_t       sel;
		logic [127:0]                pin_s1;
		logic [127:0]                pin_s2;
		logic                        cmp_s1;
		logic                        cmp_s2;
		input_remap_pkg::periph_in_t outp;
		logic [31:0]                 rdata;
		logic                        ready;
		logic                        err;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	// Elaboration check: the pin vector is fixed at 128 wide
	if (input_remap_pkg::PIN_COUNT != 128) begin : g_pin_chk
		$error("pin count must be 128");
	end

	// Source lookup; all_ones_pin chooses which code reaches pin 124
	function automatic logic route(input logic [6:0] code,
			input logic all_ones_pin, input logic [127:0] pins,
			input logic cmp);
		logic r;
		r = 1'b0;
		if (code == input_remap_pkg::CODE_VSS)
			r = 1'b0;
		else if (code == input_remap_pkg::CODE_COMPARATOR_ONE_OUTPUT)
			r = cmp;
		else if (all_ones_pin && code == input_remap_pkg::CODE_ONES)
			r = pins[124];
		else if (!all_ones_pin && code == input_remap_pkg::CODE_IPIN)
			r = pins[124];
		else if (!all_ones_pin && code > input_remap_pkg::CODE_IPIN)
			r = 1'b0;
		else
			r = pins[code];
		return r;
	endfunction

	// Two-field register image; bits 15 and 7 always zero
	function automatic logic [31:0] pack2(input logic [6:0] hi,
			input logic [6:0] lo);
		return {16'h0000, 1'b0, hi, 1'b0, lo};
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic        wr;
		logic        acc;
		logic [6:0]  hi;
		logic [6:0]  lo;
		logic        hit;
		st_nxt = st_r;
		acc    = psel && !penable;
		wr     = psel && penable && pwrite && st_r.ready;
		hi     = pwdata[input_remap_pkg::HI_LSB +: input_remap_pkg::SEL_W];
		lo     = pwdata[input_remap_pkg::LO_LSB +: input_remap_pkg::SEL_W];
		hit    = 1'b1;
		// Pin and comparator synchronisers
		st_nxt.pin_s1 = remappable_pin;
		st_nxt.pin_s2 = st_r.pin_s1;
		st_nxt.cmp_s1 = comparator_one_output;
		st_nxt.cmp_s2 = st_r.cmp_s1;
		// Register writes land at the access edge
		if (wr) begin
			case (paddr)
			input_remap_pkg::CAN_SEL_OFF: begin
				if (HAS_CAN) begin
					st_nxt.sel.can_b_rx_source = hi;
					st_nxt.sel.can_a_rx_source = lo;
				end
			end
			input_remap_pkg::UART_C_OFF: begin
				st_nxt.sel.uart_c_cts_source = hi;
				st_nxt.sel.uart_c_rx_source  = lo;
			end
			input_remap_pkg::UART_D_OFF: begin
				st_nxt.sel.uart_d_cts_source = hi;
				st_nxt.sel.uart_d_rx_source  = lo;
			end
			input_remap_pkg::SPI_CD_OFF: begin
				st_nxt.sel.spi_c_clock_source   = hi;
				st_nxt.sel.spi_c_data_in_source = lo;
			end
			input_remap_pkg::SPI_SS_OFF: begin
				st_nxt.sel.spi_c_select_source = lo;
			end
			input_remap_pkg::PWM_SYNC_OFF: begin
				st_nxt.sel.pwm_sync_one_source = hi;
			end
			default: begin
			end
			endcase
		end
		// Setup cycle: decode address, prepare read data for access
		st_nxt.ready = acc;
		if (acc) begin
			case (paddr)
			input_remap_pkg::CAN_SEL_OFF: begin
				st_nxt.rdata = HAS_CAN ? pack2(st_r.sel.can_b_rx_source,
					st_r.sel.can_a_rx_source) : 32'h0000_0000;
				hit = HAS_CAN;
			end
			input_remap_pkg::UART_C_OFF:
				st_nxt.rdata = pack2(st_r.sel.uart_c_cts_source,
					st_r.sel.uart_c_rx_source);
			input_remap_pkg::UART_D_OFF:
				st_nxt.rdata = pack2(st_r.sel.uart_d_cts_source,
					st_r.sel.uart_d_rx_source);
			input_remap_pkg::SPI_CD_OFF:
				st_nxt.rdata = pack2(st_r.sel.spi_c_clock_source,
					st_r.sel.spi_c_data_in_source);
			input_remap_pkg::SPI_SS_OFF:
				st_nxt.rdata = {25'h0, st_r.sel.spi_c_select_source};
			input_remap_pkg::PWM_SYNC_OFF:
				st_nxt.rdata = {16'h0, 1'b0,
					st_r.sel.pwm_sync_one_source, 8'h00};
			default: begin
				st_nxt.rdata = 32'h0000_0000;
				hit = 1'b0;
			end
			endcase
			st_nxt.err = !hit;
		end else begin
			st_nxt.rdata = 32'h0000_0000;
			st_nxt.err   = 1'b0;
		end
		// Routing uses the registered selectors, so a write shows a cycle on
		st_nxt.outp.can_b_receive_input = HAS_CAN && route(
			st_r.sel.can_b_rx_source, 1'b0, st_r.pin_s2, st_r.cmp_s2);
		st_nxt.outp.can_a_receive_input = HAS_CAN && route(
			st_r.sel.can_a_rx_source, 1'b0, st_r.pin_s2, st_r.cmp_s2);
		st_nxt.outp.uart_c_clear_to_send = route(
			st_r.sel.uart_c_cts_source, 1'b1, st_r.pin_s2, st_r.cmp_s2);
		st_nxt.outp.uart_c_receive_input = route(
			st_r.sel.uart_c_rx_source, 1'b1, st_r.pin_s2, st_r.cmp_s2);
		st_nxt.outp.uart_d_clear_to_send = route(
			st_r.sel.uart_d_cts_source, 1'b1, st_r.pin_s2, st_r.cmp_s2);
		st_nxt.outp.uart_d_receive_input = route(
			st_r.sel.uart_d_rx_source, 1'b1, st_r.pin_s2, st_r.cmp_s2);
		st_nxt.outp.spi_c_clock_input = route(
			st_r.sel.spi_c_clock_source, 1'b1, st_r.pin_s2, st_r.cmp_s2);
		st_nxt.outp.spi_c_data_input = route(
			st_r.sel.spi_c_data_in_source, 1'b1, st_r.pin_s2, st_r.cmp_s2);
		st_nxt.outp.spi_c_slave_select_input = route(
			st_r.sel.spi_c_select_source, 1'b1, st_r.pin_s2, st_r.cmp_s2);
		st_nxt.outp.pwm_sync_input = route(
			st_r.sel.pwm_sync_one_source, 1'b0, st_r.pin_s2, st_r.cmp_s2);
		if (!clk_en)
			st_nxt = st_r;
	end

	// ----------------------------------------------------------------
	// State register; everything clears so inputs start grounded
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign prdata    = st_r.rdata;
	assign pready    = st_r.ready;
	assign pslverr   = st_r.err;
	assign periph_in = st_r.outp;

endmodule // peripheral_input_remap_select

// ### input_remap_asserts.sv
/*
 * Port checker for the input remap selector, bound to every instance.
 * Assumes clk_en is held high by the surroundings.
 */
`timescale 1ns/1ps
module input_remap_asserts (
	input wire logic        pclk,                  // Clock
	input wire logic        presetn,               // Reset, low
	input wire logic        psel,                  // Select
	input wire logic        penable,               // Access phase
	input wire logic        pwrite,                // Write
	input wire logic [11:0] paddr,                 // Address
	input wire logic [31:0] pwdata,                // Write data
	input wire logic [31:0] prdata,                // Read data
	input wire logic        pready,                // Ready
	input wire logic        pslverr,               // Error
	input wire logic        comparator_one_output, // Comparator
	input wire input_remap_pkg::periph_in_t periph_in // Routed inputs
);
	localparam logic [11:0] PW = input_remap_pkg::PWM_SYNC_OFF;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Write to the sync selector, then quiet cycles on bus and comparator
	sequence s_wr_pwm;
		pready && pwrite && paddr == PW;
	endsequence
	sequence s_calm;
		($stable(comparator_one_output) && !pready)[*4];
	endsequence
	property p_ready;
		psel && !penable |=> pready;
	endproperty
	property p_pulse;
		pready |=> !pready;
	endproperty
	property p_err;
		pready && paddr > PW |-> pslverr;
	endproperty
	property p_res;
		pready && !pwrite && !pslverr |-> prdata[31:15] == 17'h0 && !prdata[7];
	endproperty
	property p_ss;
		pready && !pwrite && paddr == input_remap_pkg::SPI_SS_OFF
			|-> prdata[15:7] == 9'h0;
	endproperty
	property p_pwm_lo;
		pready && !pwrite && paddr == PW |-> prdata[7:0] == 8'h0;
	endproperty
	property p_low;
		s_wr_pwm ##0 pwdata[14:8] == 7'h00 ##1 !pready
			|=> !periph_in.pwm_sync_input;
	endproperty
	// Comparator path is synchronised too, so only a steady comparator is compared
	property p_cmp;
		s_wr_pwm ##0 pwdata[14:8] == 7'h01 ##1 s_calm
			|-> periph_in.pwm_sync_input == comparator_one_output;
	endproperty
	property p_reset;
		$rose(presetn) |-> periph_in == 10'h0 && !pready;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready");
	a_pulse: assert property (p_pulse) else $error("long ready");
	a_err: assert property (p_err) else $error("no error");
	a_res: assert property (p_res) else $error("spare bits");
	a_ss: assert property (p_ss) else $error("select bits");
	a_pwm_lo: assert property (p_pwm_lo) else $error("low byte");
	a_low: assert property (p_low) else $error("not tied low");
	a_cmp: assert property (p_cmp) else $error("no comparator");
	a_reset: assert property (p_reset) else $error("reset state");
endmodule // input_remap_asserts

bind peripheral_input_remap_select input_remap_asserts
	input_remap_asserts_inst (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .comparator_one_output, .periph_in);

// ### remap_pin_model.sv
/*
 * Far side: pin levels and comparator output.
 * Assumes the bench moves its controls just after a clock edge.
 */
`timescale 1ns/1ps
module remap_pin_model (
	input  wire logic [6:0] hot,     // Pin that shows lvl
	input  wire logic       lvl,     // Level of that pin
	input  wire logic       cmp_lvl, // Comparator level
	output logic [127:0]    pins,    // Pin levels
	output logic            cmp      // Comparator output
);
	// Other pins take the inverse, so a wrong pick is seen
	always_comb begin
		pins = {128{~lvl}};
		pins[hot] = lvl;
		cmp = cmp_lvl;
	end
endmodule // remap_pin_model

// ### test_peripheral_input_remap_select.sv
/*
 * Self-checking bench for the input remap selector.
 * Assumes the package and design files are compiled first.
 */
`timescale 1ns/1ps
module test_peripheral_input_remap_select;
	logic        pclk = 1'h0;
	logic        presetn = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, v_pslverr, e, ve;
	logic [6:0]  hot = 7'h0;
	logic        lvl = 1'h0;
	logic        cmp_lvl = 1'h0;
	logic        clk_en = 1'h1;
	logic [127:0] pins;
	logic        cmp;
	input_remap_pkg::periph_in_t periph_in;
	int          error_cnt = 0;
	int          compares = 0;
	// 20 MHz clock
	always #25 pclk = ~pclk;
	peripheral_input_remap_select peripheral_input_remap_select_inst (
		.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .remappable_pin(pins),
		.comparator_one_output(cmp), .periph_in);
	// Variant without CAN, same bus, only its error flag is watched
	peripheral_input_remap_select #(.HAS_CAN(1'h0))
		peripheral_input_remap_select_inst2 (
		.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata(), .pready(), .pslverr(v_pslverr),
		.remappable_pin(pins), .comparator_one_output(cmp), .periph_in());
	remap_pin_model remap_pin_model_inst (.hot, .lvl, .cmp_lvl, .pins, .cmp);
	task test_done;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, x, g);
		end
	endtask
	// One transfer; an idle edge first so no signal is set twice at once
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		if (n >= 16) begin
			error_cnt++;
			test_done;
		end
		rd = prdata;
		e = pslverr;
		ve = v_pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task t_regs;
		logic [11:0] a [6] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010,
			12'h014};
		logic [31:0] m [6] = '{32'h7f7f, 32'h7f7f, 32'h7f7f, 32'h7f7f,
			32'h007f, 32'h7f00};
		for (int i = 0; i < 6; i++) begin
			apb(1'h0, a[i], 32'h0);
			chk("reset value", 32'h0, rd);
			apb(1'h1, a[i], 32'hffffffff);
			apb(1'h0, a[i], 32'h0);
			chk("field mask", m[i], rd);
			apb(1'h1, a[i], 32'h0);
		end
		apb(1'h0, 12'h018, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, e});
		apb(1'h0, input_remap_pkg::CAN_SEL_OFF, 32'h0);
		chk("variant error", 32'h1, {31'h0, ve});
	endtask
	// Set pins, write a selector, let the sync stages settle, compare
	task rt(input logic [11:0] a, input logic [31:0] d, input logic [6:0] h,
		input logic l, input logic c, input logic [9:0] m, input logic [9:0] x);
		hot <= h;
		lvl <= l;
		cmp_lvl <= c;
		apb(1'h1, a, d);
		repeat (4) @(posedge pclk);
		chk("routed input", {22'h0, x}, {22'h0, periph_in & m});
	endtask
	task t_route;
		rt(input_remap_pkg::CAN_SEL_OFF, 32'h7c7c, 7'h7c, 1'h1, 1'h0,
			10'h300, 10'h300);
		rt(input_remap_pkg::CAN_SEL_OFF, 32'h7e01, 7'h05, 1'h0, 1'h1,
			10'h300, 10'h100);
		rt(input_remap_pkg::UART_C_OFF, 32'h7f25, 7'h7c, 1'h1, 1'h0,
			10'h0c0, 10'h080);
		rt(input_remap_pkg::UART_D_OFF, 32'h257f, 7'h7c, 1'h1, 1'h0,
			10'h030, 10'h010);
		rt(input_remap_pkg::SPI_CD_OFF, 32'h0025, 7'h25, 1'h1, 1'h0,
			10'h00c, 10'h004);
		rt(input_remap_pkg::SPI_SS_OFF, 32'h007f, 7'h7c, 1'h1, 1'h0,
			10'h002, 10'h002);
		rt(input_remap_pkg::PWM_SYNC_OFF, 32'h7c00, 7'h7c, 1'h1, 1'h0,
			10'h001, 10'h001);
		rt(input_remap_pkg::PWM_SYNC_OFF, 32'h0100, 7'h00, 1'h0, 1'h1,
			10'h001, 10'h001);
		rt(input_remap_pkg::PWM_SYNC_OFF, 32'h0000, 7'h00, 1'h1, 1'h1,
			10'h001, 10'h000);
	endtask
	// Clock enable low freezes routing even when the source moves
	task t_hold;
		rt(input_remap_pkg::PWM_SYNC_OFF, 32'h0100, 7'h00, 1'h0, 1'h0,
			10'h001, 10'h000);
		clk_en <= 1'h0;
		cmp_lvl <= 1'h1;
		repeat (6) @(posedge pclk);
		chk("frozen input", 32'h0,
			{31'h0, periph_in.pwm_sync_input});
		clk_en <= 1'h1;
		repeat (4) @(posedge pclk);
		chk("thawed input", 32'h1,
			{31'h0, periph_in.pwm_sync_input});
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		t_regs;
		t_route;
		t_hold;
		test_done;
	end
endmodule // test_peripheral_input_remap_select
